// ===== src/tisu_top.sv
// Timer, two-source interrupt unit and sleep control with Avalon slave
// Functional notes
// - Mode bits 7:5 pick stop, core, rsv, pin A4, fast, rsv, slow, pin A0.
// - Selected clock passes a prescaler dividing by 1, 4, 16 or 64.
// - Mode bits 2:0 pick counter bit 8 to 15 as timer request.
// - Counter is 16 bits, counts up once per prescaled tick.
// - Store loads counter from a word; load reads counter value.
// - Edge-select bit 4 picks rising or falling edge of chosen bit.
// - Timer request sets request flag bit 2.
// - Two request lines, pin A0 and timer, each with enable bit.
// - Only hardware sets flags; writing zero to a flag clears it.
// - Events set flags even when their enable bit is zero.
// - Pin flag edge selectable: rising, falling or both.
// - Global enable gates all requests before an interrupt is taken.
// - Entry pushes PC, adds 2 to pointer, clears global enable, jumps 0x010.
// - Return pops PC, subtracts 2, sets global enable, resumes.
// - Push and pop save and restore working and flag registers.
// - Light sleep gates only the core clock; oscillators keep state.
// - Deep sleep stops both oscillators; light sleep does not.
// - In light sleep timer stops on core clock or disabled oscillator.
// - Light sleep ends on enabled pin toggle or oscillator-timer request.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tisu_params.svh"
module tisu_top import tisu_pkg::*; (
    input wire logic sys_clk, // system clock, 25 MHz
    input wire logic rst_n, // asynchronous reset
    input wire logic [5:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic [7:0] port_a_pins, // port A pin levels
    input wire logic fast_osc_tick, // fast oscillator tick
    input wire logic slow_osc_tick, // slow oscillator tick
    input wire tisu_core_in_t core_in, // core state to save
    output var tisu_core_out_t core_out, // core control
    output logic fast_osc_en, // fast oscillator runs
    output logic slow_osc_en // slow oscillator runs
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic pre_hit(input logic [1:0] div,
                                     input logic [5:0] pre);
        case (div)
            2'h0: pre_hit = 1'b1;
            2'h1: pre_hit = &pre[1:0];
            2'h2: pre_hit = &pre[3:0];
            2'h3: pre_hit = &pre[5:0];
            default: pre_hit = 1'b0;
        endcase
    endfunction : pre_hit

    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic now,
                                      input logic prev);
        case (sel)
            2'h1: edge_hit = now & ~prev;
            2'h2: edge_hit = ~now & prev;
            default: edge_hit = now ^ prev;
        endcase
    endfunction : edge_hit

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] mode;
    logic [7:0] src_en;
    logic [7:0] req_flag;
    logic [7:0] edge_sel;
    logic [15:0] count;
    logic [7:0] stack_ptr;
    logic [1:0] osc_ctrl;
    logic [7:0] wake_en;
    logic [5:0] prescale;
    logic [7:0] pins_q;
    logic sel_q;
    logic gie;
    logic light_sleep;
    logic deep_sleep;
    logic ack;
    logic pop_is_reti;
    tisu_state_t state;
    logic fetch_load;
    logic [15:0] fetch_addr;
    logic restore;
    logic [7:0] acc_out;
    logic [7:0] flag_out;
    logic [15:0] mem_rdata;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic req = avs_read | avs_write;
    wire logic busy = (state != TISU_ST_IDLE);
    wire logic [3:0] idx = avs_address[5:2];
    wire logic [7:0] wd8 = avs_writedata[7:0];
    wire logic wr_now = avs_write & ack;
    wire logic wr_lo = wr_now & avs_byteenable[0];
    wire logic src_en_wr = wr_lo & (idx == `TISU_IDX_SRC_EN);
    wire logic flag_wr = wr_lo & (idx == `TISU_IDX_REQ_FLAG);
    wire logic edge_wr = wr_lo & (idx == `TISU_IDX_EDGE_SEL);
    wire logic cnt_wr = wr_now & (idx == `TISU_IDX_COUNT);
    wire logic sp_wr = wr_lo & (idx == `TISU_IDX_STACK_PTR);
    wire logic ctrl_wr = wr_lo & (idx == `TISU_IDX_CORE_CTRL);
    wire logic mode_wr = wr_lo & (idx == `TISU_IDX_MODE);
    wire logic osc_wr = wr_lo & (idx == `TISU_IDX_OSC_CTRL);
    wire logic wake_wr = wr_lo & (idx == `TISU_IDX_WAKE_EN);

    assign avs_waitrequest = req & ~ack;

    // ------------------------------------------------------------
    // Clock sources and prescaler
    // ------------------------------------------------------------
    wire logic core_run = ~light_sleep & ~deep_sleep;
    assign fast_osc_en = osc_ctrl[0] & ~deep_sleep;
    assign slow_osc_en = osc_ctrl[1] & ~deep_sleep;
    wire tisu_src_t src = tisu_src_t'(mode[`TISU_MODE_SRC]);
    wire logic a0_rise = port_a_pins[0] & ~pins_q[0];
    wire logic a4_rise = port_a_pins[4] & ~pins_q[4];
    logic src_tick;

    always_comb begin
        case (src)
            TISU_SRC_CORE: src_tick = core_run;
            TISU_SRC_PIN4: src_tick = a4_rise;
            TISU_SRC_FAST: src_tick = fast_osc_tick & fast_osc_en;
            TISU_SRC_SLOW: src_tick = slow_osc_tick & slow_osc_en;
            TISU_SRC_PIN0: src_tick = a0_rise;
            default: src_tick = 1'b0;
        endcase
    end

    wire logic pre_tick = src_tick & pre_hit(mode[`TISU_MODE_DIV], prescale);

    // ------------------------------------------------------------
    // Counter and timer request
    // ------------------------------------------------------------
    logic [15:0] next_count;

    always_comb begin
        next_count = pre_tick ? count + 16'h0001 : count;
        if (cnt_wr & avs_byteenable[0]) begin
            next_count[7:0] = avs_writedata[7:0];
        end
        if (cnt_wr & avs_byteenable[1]) begin
            next_count[15:8] = avs_writedata[15:8];
        end
    end

    wire logic sel_bit = count[{1'b1, mode[`TISU_MODE_BIT]}];
    wire logic tmr_evt = edge_sel[`TISU_EDGE_TMR] ? (sel_q & ~sel_bit)
                                                  : (~sel_q & sel_bit);
    wire logic pin_evt = edge_hit(edge_sel[`TISU_EDGE_PIN],
                                  port_a_pins[0], pins_q[0]);

    // ------------------------------------------------------------
    // Request flags and interrupt entry
    // ------------------------------------------------------------
    wire logic [7:0] flag_set = {5'h00, tmr_evt, 1'b0, pin_evt};
    wire logic [7:0] next_flag = (flag_set |
                                  (flag_wr ? (req_flag & wd8) : req_flag))
                                 & `TISU_FLAG_MASK;
    wire logic pending = |(req_flag & src_en & `TISU_FLAG_MASK);
    wire logic take_int = gie & pending & core_run & ~busy
                          & ~ctrl_wr & ~sp_wr;

    // ------------------------------------------------------------
    // Stack commands
    // ------------------------------------------------------------
    wire logic do_reti = ctrl_wr & wd8[`TISU_CMD_RETI];
    wire logic do_pop = ctrl_wr & wd8[`TISU_CMD_POP] & ~do_reti;
    wire logic do_push = ctrl_wr & wd8[`TISU_CMD_PUSH] & ~do_reti
                         & ~wd8[`TISU_CMD_POP];
    wire logic [7:0] sp_dec = stack_ptr - `TISU_SP_STEP;
    wire logic [7:0] sp_inc = stack_ptr + `TISU_SP_STEP;
    wire logic mem_we = take_int | do_push;
    wire logic [15:0] mem_wdata = take_int ? core_in.pc
                                           : {core_in.flag, core_in.acc};
    logic [7:0] next_sp;

    always_comb begin
        next_sp = stack_ptr;
        if (sp_wr) begin
            next_sp = wd8;
        end else if (mem_we) begin
            next_sp = sp_inc;
        end else if (do_reti | do_pop) begin
            next_sp = sp_dec;
        end
    end

    tisu_stack_mem u_stack (
        .sys_clk(sys_clk),
        .we(mem_we),
        .waddr(stack_ptr[5:1]),
        .wdata(mem_wdata),
        .raddr(sp_dec[5:1]),
        .rdata(mem_rdata)
    );

    // ------------------------------------------------------------
    // Sleep and wake
    // ------------------------------------------------------------
    wire logic pin_toggle = |((port_a_pins ^ pins_q) & wake_en);
    wire logic tmr_wake = tmr_evt & ((src == TISU_SRC_FAST) |
                                     (src == TISU_SRC_SLOW));
    // light sleep gates core clock only
    wire logic next_light = light_sleep ? ~(pin_toggle | tmr_wake)
                                        : ctrl_wr & wd8[`TISU_CMD_LSLEEP];
    wire logic next_deep = deep_sleep ? ~pin_toggle
                                      : ctrl_wr & wd8[`TISU_CMD_DSLEEP];
    wire logic pop_done = (state == TISU_ST_POP);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire logic [7:0] ctrl_stat = {4'h0, core_run, deep_sleep,
                                  light_sleep, gie};
    wire logic [31:0] rd_mux =
        (idx == `TISU_IDX_SRC_EN) ? {24'h000000, src_en} :
        (idx == `TISU_IDX_REQ_FLAG) ? {24'h000000, req_flag} :
        (idx == `TISU_IDX_EDGE_SEL) ? {24'h000000, edge_sel} :
        (idx == `TISU_IDX_COUNT) ? {16'h0000, count} :
        (idx == `TISU_IDX_STACK_PTR) ? {24'h000000, stack_ptr} :
        (idx == `TISU_IDX_CORE_CTRL) ? {24'h000000, ctrl_stat} :
        (idx == `TISU_IDX_MODE) ? {24'h000000, mode} :
        (idx == `TISU_IDX_OSC_CTRL) ? {30'h0, osc_ctrl} :
        (idx == `TISU_IDX_WAKE_EN) ? {24'h000000, wake_en} :
        32'h00000000;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            ack <= req & ~ack & ~busy;
            if (avs_read & ~ack & ~busy) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= `TISU_MODE_RST;
            src_en <= 8'h00;
            edge_sel <= 8'h00;
            osc_ctrl <= `TISU_OSC_RST;
            wake_en <= 8'h00;
        end else begin
            if (mode_wr) begin
                mode <= wd8;
            end
            if (src_en_wr) begin
                src_en <= wd8 & `TISU_FLAG_MASK;
            end
            if (edge_wr) begin
                edge_sel <= wd8;
            end
            if (osc_wr) begin
                osc_ctrl <= wd8[1:0];
            end
            if (wake_wr) begin
                wake_en <= wd8;
            end
        end
    end

    // ------------------------------------------------------------
    // Timer and flags
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 16'h0000;
            prescale <= 6'h00;
            pins_q <= 8'h00;
            sel_q <= 1'b0;
            req_flag <= 8'h00;
        end else begin
            count <= next_count;
            prescale <= src_tick ? prescale + 6'h01 : prescale;
            pins_q <= port_a_pins;
            sel_q <= sel_bit;
            req_flag <= next_flag;
        end
    end

    // ------------------------------------------------------------
    // Sequencer, stack and global enable
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= TISU_ST_IDLE;
            pop_is_reti <= 1'b0;
            stack_ptr <= 8'h00;
            gie <= 1'b0;
            light_sleep <= 1'b0;
            deep_sleep <= 1'b0;
        end else begin
            stack_ptr <= next_sp;
            light_sleep <= next_light;
            deep_sleep <= next_deep;
            case (state)
                TISU_ST_IDLE: begin
                    if (do_reti | do_pop) begin
                        state <= TISU_ST_POP;
                        pop_is_reti <= do_reti;
                    end
                end
                TISU_ST_POP: begin
                    state <= TISU_ST_IDLE;
                end
                default: begin
                    state <= TISU_ST_IDLE;
                end
            endcase
            if (take_int) begin
                gie <= 1'b0;
            end else if (pop_done & pop_is_reti) begin
                gie <= 1'b1;
            end else if (ctrl_wr & wd8[`TISU_CMD_GIE_OFF]) begin
                gie <= 1'b0;
            end else if (ctrl_wr & wd8[`TISU_CMD_GIE_ON]) begin
                gie <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Core side outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_load <= 1'b0;
            fetch_addr <= 16'h0000;
            restore <= 1'b0;
            acc_out <= 8'h00;
            flag_out <= 8'h00;
        end else begin
            fetch_load <= take_int | (pop_done & pop_is_reti);
            restore <= pop_done & ~pop_is_reti;
            if (take_int) begin
                fetch_addr <= `TISU_INT_VECTOR;
            end else if (pop_done & pop_is_reti) begin
                fetch_addr <= mem_rdata;
            end
            if (pop_done & ~pop_is_reti) begin
                acc_out <= mem_rdata[7:0];
                flag_out <= mem_rdata[15:8];
            end
        end
    end

    assign core_out.run = core_run;
    assign core_out.fetch_load = fetch_load;
    assign core_out.fetch_addr = fetch_addr;
    assign core_out.restore = restore;
    assign core_out.acc = acc_out;
    assign core_out.flag = flag_out;
endmodule : tisu_top
`default_nettype wire

// ===== src/tisu_params.svh
// Register map, field positions, reset values and fixed addresses
`ifndef TISU_PARAMS_SVH
`define TISU_PARAMS_SVH
// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define TISU_IDX_SRC_EN 4'h0
`define TISU_IDX_REQ_FLAG 4'h1
`define TISU_IDX_EDGE_SEL 4'h2
`define TISU_IDX_COUNT 4'h3
`define TISU_IDX_STACK_PTR 4'h4
`define TISU_IDX_CORE_CTRL 4'h5
`define TISU_IDX_MODE 4'h6
`define TISU_IDX_OSC_CTRL 4'h7
`define TISU_IDX_WAKE_EN 4'h8
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define TISU_MODE_SRC 7:5
`define TISU_MODE_DIV 4:3
`define TISU_MODE_BIT 2:0
`define TISU_EDGE_PIN 1:0
`define TISU_EDGE_TMR 4
`define TISU_FLAG_PIN 0
`define TISU_FLAG_TMR 2
`define TISU_FLAG_MASK 8'h05
`define TISU_CMD_GIE_ON 0
`define TISU_CMD_GIE_OFF 1
`define TISU_CMD_RETI 2
`define TISU_CMD_LSLEEP 3
`define TISU_CMD_DSLEEP 4
`define TISU_CMD_PUSH 5
`define TISU_CMD_POP 6
// ------------------------------------------------------------
// Reset values and fixed numbers
// ------------------------------------------------------------
`define TISU_MODE_RST 8'h00
`define TISU_OSC_RST 2'h3
`define TISU_INT_VECTOR 16'h0010
`define TISU_SP_STEP 8'h02
`endif

// ===== src/tisu_pkg.sv
// Types shared by the timer, interrupt and sleep unit
package tisu_pkg;
    typedef enum logic [2:0] {
        TISU_SRC_STOP = 3'h0,
        TISU_SRC_CORE = 3'h1,
        TISU_SRC_RSV2 = 3'h2,
        TISU_SRC_PIN4 = 3'h3,
        TISU_SRC_FAST = 3'h4,
        TISU_SRC_RSV5 = 3'h5,
        TISU_SRC_SLOW = 3'h6,
        TISU_SRC_PIN0 = 3'h7
    } tisu_src_t;
    typedef enum logic [1:0] {
        TISU_ST_IDLE = 2'h0,
        TISU_ST_POP = 2'h1
    } tisu_state_t;
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] acc;
        logic [7:0] flag;
    } tisu_core_in_t;
    typedef struct packed {
        logic run;
        logic fetch_load;
        logic [15:0] fetch_addr;
        logic restore;
        logic [7:0] acc;
        logic [7:0] flag;
    } tisu_core_out_t;
endpackage : tisu_pkg

// ===== src/tisu_stack_mem.sv
// Word-wide stack memory with a registered read port
`timescale 1ns/10ps
`default_nettype none
module tisu_stack_mem (
    input wire logic sys_clk, // system clock
    input wire logic we, // write strobe
    input wire logic [4:0] waddr, // write word address
    input wire logic [15:0] wdata, // write data
    input wire logic [4:0] raddr, // read word address
    output logic [15:0] rdata // read data, one cycle later
);
    logic [15:0] mem [0:31];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : tisu_stack_mem
`default_nettype wire

// ===== bench/tisu_props.sv
// Concurrent checks on the unit's top ports
`timescale 1ns/10ps
`default_nettype none
`include "tisu_params.svh"
module tisu_props import tisu_pkg::*; (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset
    input wire logic [5:0] avs_address, // address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest, // stall
    input wire tisu_core_out_t core_out, // core control
    input wire logic fast_osc_en, // fast osc on
    input wire logic slow_osc_en // slow osc on
);
    wire req = avs_read || avs_write;
    wire wr_done = avs_write && !avs_waitrequest;
    wire ctl_done = wr_done && avs_address[5:2] == `TISU_IDX_CORE_CTRL;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("no stall on first request cycle");
    bus_answer_a: assert property (req |-> ##[0:3] !avs_waitrequest)
        else $error("request not answered");
    wait_idle_a: assert property (!req |-> !avs_waitrequest)
        else $error("stall while idle");
    rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
        else $error("read data moved without read");
    osc_keep_a: assert property (($changed(fast_osc_en) || $changed(slow_osc_en))
        && $past(core_out.run) |-> $past(wr_done))
        else $error("oscillator enable moved by itself");
    run_fall_a: assert property ($fell(core_out.run) |-> $past(ctl_done)
        || $past(ctl_done, 2))
        else $error("core halted without sleep command");
    fetch_once_a: assert property (core_out.fetch_load |=> !core_out.fetch_load)
        else $error("fetch pulse too long");
    ret_fetch_a: assert property (core_out.fetch_load
        && core_out.fetch_addr != `TISU_INT_VECTOR |-> $past(ctl_done, 2))
        else $error("return fetch without return command");
    restore_src_a: assert property (core_out.restore |-> $past(ctl_done, 2))
        else $error("restore without pop command");
    cover property (core_out.fetch_load);
    cover property (core_out.restore);
    cover property ($fell(slow_osc_en));
endmodule : tisu_props
bind tisu_top tisu_props tisu_props_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_out(core_out), .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en));
`default_nettype wire

// ===== bench/tisu_core_model.sv
// Behavioural processor core on the unit's core port
`timescale 1ns/10ps
`default_nettype none
module tisu_core_model import tisu_pkg::*; #(
    parameter logic [15:0] START_PC = 16'h0123
) (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset
    input wire tisu_core_out_t core_out, // control from unit
    output var tisu_core_in_t core_in // state to save
);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_in <= {START_PC, 8'h5A, 8'hC3};
        end else begin
            if (core_out.fetch_load) begin
                core_in.pc <= core_out.fetch_addr;
                core_in.acc <= ~core_in.acc;
            end
            if (core_out.restore) begin
                core_in.acc <= core_out.acc;
                core_in.flag <= core_out.flag;
            end
        end
    end
endmodule : tisu_core_model
`default_nettype wire

// ===== bench/tisu_top_tb.sv
// Self-checking bench for the timer, interrupt and sleep unit
`timescale 1ns/10ps
`default_nettype none
module tisu_top_tb import tisu_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [9:0] stim = 10'h000;
    tisu_core_in_t core_in;
    tisu_core_out_t core_out;
    logic fast_osc_en;
    logic slow_osc_en;
    int n_fail = 0;
    int checks = 0;
    int n_fetch = 0;
    logic [15:0] last_fetch;
    logic [15:0] last_rest;
    logic [15:0] saved;
    logic [31:0] q;
    logic [7:0] md [8] = '{8'h68, 8'h90, 8'hD8, 8'hE0,
                           8'h40, 8'hA0, 8'h00, 8'h60};
    int pb [8] = '{4, 8, 9, 0, 4, 4, 4, 4};
    int pn [8] = '{8, 32, 128, 3, 4, 4, 4, 2};
    logic [15:0] inc [8] = '{16'h2, 16'h2, 16'h2, 16'h3,
                             16'h0, 16'h0, 16'h0, 16'h2};
    tisu_top tisu_top_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_a_pins(stim[7:0]), .fast_osc_tick(stim[8]),
        .slow_osc_tick(stim[9]), .core_in(core_in), .core_out(core_out),
        .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en));
    tisu_core_model tisu_core_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .core_out(core_out), .core_in(core_in));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (core_out.fetch_load === 1'b1) begin
            n_fetch++;
            last_fetch <= core_out.fetch_addr;
        end
        if (core_out.restore === 1'b1) begin
            last_rest <= {core_out.acc, core_out.flag};
        end
    end
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
        if (n >= 50) cmp("bus answer", 32'h1, 32'h0);
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic chk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp($sformatf("reg %h", a), e, q);
    endtask : chk
    task automatic pulse(input int b, input int n);
        repeat (n) begin
            stim[b] <= 1'b1;
            @(posedge sys_clk);
            stim[b] <= 1'b0;
            @(posedge sys_clk);
        end
        repeat (4) @(posedge sys_clk);
    endtask : pulse
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_fail, checks);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk(6'h18, 32'h0);
        chk(6'h1C, 32'h3);
        chk(6'h14, 32'h8);
        chk(6'h3C, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(6'h18, 32'h0);
            wr(6'h0C, i == 7 ? 32'hFFFF : 32'h1000);
            wr(6'h18, {24'h0, md[i]});
            pulse(pb[i], pn[i]);
            wr(6'h18, 32'h0);
            chk(6'h0C, {16'h0, (i == 7 ? 16'hFFFF : 16'h1000) + inc[i]});
        end
        for (int i = 0; i < 2; i++) begin
            wr(6'h0C, i ? 32'h01FE : 32'h00FE);
            wr(6'h04, 32'h0);
            wr(6'h08, i ? 32'h10 : 32'h0);
            wr(6'h18, 32'h60);
            pulse(4, 4);
            wr(6'h18, 32'h0);
            chk(6'h04, 32'h4);
        end
        wr(6'h04, 32'hFF);
        chk(6'h04, 32'h4);
        for (int s = 1; s < 4; s++) begin
            wr(6'h08, s);
            wr(6'h04, 32'h0);
            stim[0] <= 1'b1;
            repeat (3) @(posedge sys_clk);
            chk(6'h04, {31'h0, s != 2});
            wr(6'h04, 32'h0);
            stim[0] <= 1'b0;
            repeat (3) @(posedge sys_clk);
            chk(6'h04, {31'h0, s != 1});
        end
        wr(6'h00, 32'h1);
        wr(6'h10, 32'h10);
        repeat (4) @(posedge sys_clk);
        cmp("early entry", 32'h0, 32'(n_fetch));
        wr(6'h14, 32'h1);
        repeat (4) @(posedge sys_clk);
        cmp("vector", 32'h0010, {16'h0, last_fetch});
        chk(6'h10, 32'h12);
        chk(6'h14, 32'h8);
        wr(6'h04, 32'h0);
        saved = core_in[15:0];
        wr(6'h14, 32'h20);
        chk(6'h10, 32'h14);
        wr(6'h14, 32'h40);
        repeat (4) @(posedge sys_clk);
        cmp("restored", {16'h0, saved}, {16'h0, last_rest});
        wr(6'h14, 32'h4);
        repeat (4) @(posedge sys_clk);
        cmp("return", 32'h0123, {16'h0, last_fetch});
        chk(6'h10, 32'h10);
        chk(6'h14, 32'h9);
        wr(6'h00, 32'h0);
        wr(6'h20, 32'h10);
        wr(6'h14, 32'h8);
        cmp("light", 32'h3, {29'h0, core_out.run, fast_osc_en, slow_osc_en});
        pulse(4, 1);
        cmp("pin wake", 32'h1, {31'h0, core_out.run});
        wr(6'h0C, 32'h00FE);
        wr(6'h18, 32'h80);
        wr(6'h14, 32'h8);
        pulse(8, 4);
        cmp("timer wake", 32'h1, {31'h0, core_out.run});
        wr(6'h18, 32'h20);
        wr(6'h14, 32'h8);
        bus(1'b0, 6'h0C, 32'h0);
        saved = q[15:0];
        cmp("core count", 32'h1, {31'h0, saved > 16'h0102});
        repeat (8) @(posedge sys_clk);
        chk(6'h0C, {16'h0, saved});
        pulse(4, 1);
        wr(6'h14, 32'h10);
        cmp("deep", 32'h0, {29'h0, core_out.run, fast_osc_en, slow_osc_en});
        pulse(4, 1);
        cmp("deep wake", 32'h7, {29'h0, core_out.run, fast_osc_en, slow_osc_en});
        finish_test();
    end
endmodule : tisu_top_tb
`default_nettype wire
